// >>> shared/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] RES_HIGH_ADDR = 8'h04;
  localparam logic [7:0] RES_LOW_ADDR = 8'h08;
  localparam logic [7:0] PRESCALE_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h10;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h14;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CHAN_LSB = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int START_BIT = 3;
  localparam int EOC_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] RES_HIGH_RESET = 8'h00;
  localparam logic [1:0] RES_LOW_RESET = 2'h0;

  // ------------------------------------------------------------------
  // Counts, result codes and bus response codes
  // ------------------------------------------------------------------
  localparam logic [7:0] PRESCALE_ZERO_HALF = 8'h20;
  localparam logic [9:0] CODE_FULL = 10'h3FF;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] chan;
    logic start;
    logic eoc;
  } ctrl_type;

  typedef struct packed {
    logic valid;
    logic over;
    logic under;
    logic [9:0] code;
  } sample_type;

endpackage : conv_ctrl_pkg

// >>> hw/conv_clock_div.sv
`timescale 1ns/1ps
module conv_clock_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [7:0] prescale_i,
  output logic tick_o
);

  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [7:0] half;

  // A tick marks each converter clock rising edge, one per 2*half cycles.
  always_comb begin
    half = (prescale_i == 8'h00) ? conv_ctrl_pkg::PRESCALE_ZERO_HALF
                                 : prescale_i;
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run_i) begin
      s_d.cnt = 9'h000;
    end else if (s_q.cnt + 9'h001 >= {half, 1'b0}) begin
      s_d.cnt = 9'h000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 9'h001;
    end
  end

  // The count is nine bits wide so that every prescaler value up to 255 works.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule : conv_clock_div

// >>> hw/conv_control.sv
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module conv_control #(
  parameter int CONV_TICKS = 11
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] chan_sel_o,
  output logic sample_req_o,
  output logic conv_clk_tick_o,
  input wire conv_ctrl_pkg::sample_type sample_i,
  output logic irq_o
);

  if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_ticks
    $error("CONV_TICKS must lie in 1..255");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SAMPLE = 2'b01,
    CONVERT = 2'b10,
    DONE = 2'b11
  } phase_type;

  typedef struct packed {
    phase_type phase;
    conv_ctrl_pkg::ctrl_type ctrl;
    logic [7:0] prescale;
    logic [7:0] irq_en;
    logic [7:0] res_high;
    logic [1:0] res_low;
    logic [9:0] pending;
    logic [7:0] ticks;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic req;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic tick;
  logic do_write;
  logic start_wr;
  logic eoc_clr;
  logic eoc_set;
  logic [9:0] code;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // ------------------------------------------------------------------
  // Converter clock prescaler
  // ------------------------------------------------------------------
  // Derived from clk_i only: the converter has no clock of its own.
  conv_clock_div u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(s_q.phase != IDLE),
    .prescale_i(s_q.prescale),
    .tick_o(tick)
  );

  // ------------------------------------------------------------------
  // Result coding
  // ------------------------------------------------------------------
  always_comb begin
    if (sample_i.over) begin
      code = conv_ctrl_pkg::CODE_FULL;
    end else if (sample_i.under) begin
      code = conv_ctrl_pkg::CODE_ZERO;
    end else begin
      code = sample_i.code;
    end
  end

  // ------------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:0])
      conv_ctrl_pkg::CTRL_ADDR: begin
        rd_word[7:0] = {3'b000, s_q.ctrl.eoc, s_q.ctrl.start,
                        s_q.ctrl.chan};
      end
      conv_ctrl_pkg::RES_HIGH_ADDR: begin
        rd_word[7:0] = s_q.res_high;
      end
      conv_ctrl_pkg::RES_LOW_ADDR: begin
        // Reserved bits read zero here rather than undefined.
        rd_word[1:0] = s_q.res_low;
      end
      conv_ctrl_pkg::PRESCALE_ADDR: begin
        rd_word[7:0] = s_q.prescale;
      end
      conv_ctrl_pkg::IRQ_EN_ADDR: begin
        rd_word[7:0] = s_q.irq_en;
      end
      conv_ctrl_pkg::IRQ_STAT_ADDR: begin
        rd_word[conv_ctrl_pkg::EOC_BIT] = s_q.ctrl.eoc;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_araddr[31:8] != 24'h000000) begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    wr_hit = (s_q.aw_addr == conv_ctrl_pkg::CTRL_ADDR)
          || (s_q.aw_addr == conv_ctrl_pkg::RES_HIGH_ADDR)
          || (s_q.aw_addr == conv_ctrl_pkg::RES_LOW_ADDR)
          || (s_q.aw_addr == conv_ctrl_pkg::PRESCALE_ADDR)
          || (s_q.aw_addr == conv_ctrl_pkg::IRQ_EN_ADDR)
          || (s_q.aw_addr == conv_ctrl_pkg::IRQ_STAT_ADDR);
    start_wr = do_write && s_q.w_strb[0]
            && (s_q.aw_addr == conv_ctrl_pkg::CTRL_ADDR)
            && s_q.w_data[conv_ctrl_pkg::START_BIT];
    // The flag is cleared by writing zero to it in the control register,
    // or by writing one to it in the status register.
    eoc_clr = do_write && s_q.w_strb[0] && (
      ((s_q.aw_addr == conv_ctrl_pkg::CTRL_ADDR)
        && !s_q.w_data[conv_ctrl_pkg::EOC_BIT])
      || ((s_q.aw_addr == conv_ctrl_pkg::IRQ_STAT_ADDR)
        && s_q.w_data[conv_ctrl_pkg::EOC_BIT]));
    eoc_set = (s_q.phase == DONE);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;

    if (!s_q.aw_full && s_axi_awvalid) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = (s_axi_awaddr[31:8] == 24'h000000)
                    ? s_axi_awaddr[7:0] : 8'hFF;
    end
    if (!s_q.w_full && s_axi_wvalid) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (!s_q.rvalid && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = rd_hit ? conv_ctrl_pkg::RESP_OKAY
                         : conv_ctrl_pkg::RESP_SLVERR;
    end

    if (do_write) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_hit ? conv_ctrl_pkg::RESP_OKAY
                         : conv_ctrl_pkg::RESP_SLVERR;
      if (s_q.w_strb[0]) begin
        unique case (s_q.aw_addr)
          conv_ctrl_pkg::CTRL_ADDR: begin
            // Channel is frozen while converting so the sample stays on
            // the channel that was chosen at the start.
            if (s_q.phase == IDLE) begin
              s_d.ctrl.chan = s_q.w_data[2:0];
            end
          end
          conv_ctrl_pkg::PRESCALE_ADDR: begin
            s_d.prescale = s_q.w_data[7:0];
          end
          conv_ctrl_pkg::IRQ_EN_ADDR: begin
            s_d.irq_en = s_q.w_data[7:0];
          end
          default: begin
          end
        endcase
      end
    end

    if (eoc_clr) begin
      s_d.ctrl.eoc = 1'b0;
    end

    unique case (s_q.phase)
      IDLE: begin
        if (start_wr) begin
          s_d.ctrl.start = 1'b1;
          s_d.phase = SAMPLE;
        end
      end
      SAMPLE: begin
        // A start write here changes nothing.
        if (tick) begin
          s_d.req = 1'b1;
          s_d.ticks = 8'h00;
          s_d.phase = CONVERT;
        end
      end
      CONVERT: begin
        if (sample_i.valid) begin
          s_d.pending = code;
        end
        if (tick) begin
          if (s_q.ticks == 8'(CONV_TICKS - 1)) begin
            s_d.phase = DONE;
          end else begin
            s_d.ticks = s_q.ticks + 8'h01;
          end
        end
      end
      DONE: begin
        s_d.res_high = s_q.pending[9:2];
        s_d.res_low = s_q.pending[1:0];
        s_d.ctrl.start = 1'b0;
        s_d.phase = IDLE;
      end
    endcase

    // Setting wins over a clear in the same cycle.
    if (eoc_set) begin
      s_d.ctrl.eoc = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.phase <= IDLE;
      s_q.ctrl <= conv_ctrl_pkg::ctrl_type'(conv_ctrl_pkg::CTRL_RESET[4:0]);
      s_q.prescale <= conv_ctrl_pkg::PRESCALE_RESET;
      s_q.irq_en <= conv_ctrl_pkg::IRQ_EN_RESET;
      s_q.res_high <= conv_ctrl_pkg::RES_HIGH_RESET;
      s_q.res_low <= conv_ctrl_pkg::RES_LOW_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign s_axi_awready = !s_q.aw_full;
  assign s_axi_wready = !s_q.w_full;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign chan_sel_o = s_q.ctrl.chan;
  assign sample_req_o = s_q.req;
  assign conv_clk_tick_o = tick;
  assign irq_o = s_q.ctrl.eoc
              && s_q.irq_en[conv_ctrl_pkg::IRQ_EN_BIT];

endmodule : conv_control

// >>> tb/conv_control_checker.sv
`timescale 1ns/1ps
// ------------------------------------
// Port checker
// ------------------------------------
module conv_control_checker #(
  parameter int CONV_TICKS = 11
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_req_o,
  input wire logic conv_clk_tick_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic wr_take;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready;
  sequence conv_start_s;
    sample_req_o;
  endsequence
  // The write acts one edge after its take, so the clear shows a cycle later.
  sequence irq_clear_s;
    wr_take && s_axi_wdata[conv_ctrl_pkg::EOC_BIT]
      && s_axi_awaddr[7:0] == conv_ctrl_pkg::IRQ_STAT_ADDR;
  endsequence
  AST_IRQ_CLEAR: assert property (irq_clear_s |=> ##1 !irq_o)
    else $error("interrupt high after flag clear");
  AST_REQ_ONCE: assert property (
    conv_start_s |=> !sample_req_o [*4])
    else $error("second sample request too soon");
  AST_TICK_PULSE: assert property (
    conv_clk_tick_o |=> !conv_clk_tick_o)
    else $error("converter tick longer than one cycle");
  // Both halves are held one cycle before the write acts and answers.
  AST_B_ANSWER: assert property (wr_take |=> ##1 s_axi_bvalid)
    else $error("no write response after write");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("no read data after read address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule : conv_control_checker

bind conv_control conv_control_checker #(.CONV_TICKS(CONV_TICKS))
  i_conv_control_checker (
  .clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .sample_req_o, .conv_clk_tick_o, .irq_o
);

// >>> tb/analog_core_model.sv
`timescale 1ns/1ps
// ------------------------------------
// Analog core model
// ------------------------------------
module analog_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] chan_sel_i,
  input wire logic sample_req_i,
  input wire logic tick_i,
  input wire logic [1:0] range_i,
  input wire logic slow_i,
  output conv_ctrl_pkg::sample_type sample_o
);
  logic busy_q, wait_q, valid_q;
  logic [9:0] junk_q, code_w;
  // The code wanders outside the valid cycle, so a late capture shows up.
  always_ff @(posedge clk_i) begin
    junk_q <= junk_q + 10'h135;
    valid_q <= 1'b0;
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      junk_q <= 10'h2A5;
    end else if (sample_req_i) begin
      busy_q <= 1'b1;
      wait_q <= slow_i;
    end else if (busy_q && tick_i) begin
      busy_q <= wait_q;
      wait_q <= 1'b0;
      valid_q <= !wait_q;
    end
  end
  assign code_w = (range_i == 2'h1) ? 10'h3FF
    : {chan_sel_i, 4'hA, chan_sel_i};
  assign sample_o = {valid_q, valid_q && range_i == 2'h2,
    valid_q && range_i == 2'h3, valid_q && range_i < 2'h2 ? code_w : junk_q};
endmodule : analog_core_model

// >>> tb/tb.sv
`timescale 1ns/1ps
// ------------------------------------
// Converter control testbench
// ------------------------------------
module tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, q;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, rdy = 1'b0, slow = 1'b0;
  logic awr, wrd, arr, bv, rv, req, tick, irq;
  logic [1:0] bresp, rresp, r, rng = 2'h0;
  logic [2:0] chan;
  conv_ctrl_pkg::sample_type smp;
  int num_errors = 0, total_checks = 0, cyc = 0, last = 0, gap = 0;

  always #4 clk_i = ~clk_i;

  conv_control #(.CONV_TICKS(4)) i_conv_control (
    .clk_i, .rst_n_i, .s_axi_awaddr(addr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(rdy), .s_axi_araddr(addr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rdy),
    .chan_sel_o(chan), .sample_req_o(req), .conv_clk_tick_o(tick),
    .sample_i(smp), .irq_o(irq));

  analog_core_model i_analog_core_model (
    .clk_i, .rst_n_i, .chan_sel_i(chan), .sample_req_i(req),
    .tick_i(tick), .range_i(rng), .slow_i(slow), .sample_o(smp));

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (tick === 1'b1) begin
      gap <= cyc - last;
      last <= cyc;
    end
  end

  function automatic int div(input logic [7:0] p);
    return (p == 8'h00) ? 64 : 2 * p;
  endfunction : div

  function automatic logic [9:0] code(input logic [2:0] c,
                                      input logic [1:0] g);
    if (g == 2'h0) return {c, 4'hA, c};
    return (g == 2'h3) ? 10'h000 : 10'h3FF;
  endfunction : code

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Ready is raised late at random, so the slave must hold its answer.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = $urandom_range(2);
    addr <= {24'h0, a};
    wdata <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    do begin
      @(posedge clk_i);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wrd === 1'b1) wv <= 1'b0;
      if (arv && arr === 1'b1) arv <= 1'b0;
      if (n-- == 0) rdy <= 1'b1;
    end while (!rdy || (w ? bv : rv) !== 1'b1);
    q = rdata;
    r = w ? bresp : rresp;
    rdy <= 1'b0;
  endtask : bus

  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    logic [2:0] c;
    logic [7:0] p;
    logic [1:0] g;
    logic [9:0] e;
    logic en;
    void'($urandom(4304));
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      check(q, 32'h0, "reset value");
    end
    bus(1'b1, 8'h40, 32'h1);
    check(r, conv_ctrl_pkg::RESP_SLVERR, "bresp");
    bus(1'b0, 8'h40, 32'h0);
    check(r, conv_ctrl_pkg::RESP_SLVERR, "rresp");
    for (int i = 0; i < 10; i++) begin
      c = (i == 1) ? 3'h7 : 3'($urandom);
      p = (i == 0) ? 8'h00 : (i == 2) ? 8'hFF : 8'($urandom_range(4, 1));
      g = (i < 4) ? 2'(i) : 2'($urandom);
      en = 1'($urandom);
      rng <= g;
      slow <= 1'($urandom);
      bus(1'b1, conv_ctrl_pkg::IRQ_EN_ADDR, {30'h0, en, 1'b0});
      bus(1'b1, conv_ctrl_pkg::PRESCALE_ADDR, {24'h0, p});
      bus(1'b1, conv_ctrl_pkg::CTRL_ADDR, {29'h1, c});
      bus(1'b1, conv_ctrl_pkg::CTRL_ADDR, {29'h1, ~c});
      check(chan, c, "channel");
      do begin
        bus(1'b0, conv_ctrl_pkg::CTRL_ADDR, 32'h0);
      end while (q[3] !== 1'b0);
      check(q, {29'h2, c}, "control");
      e = code(c, g);
      bus(1'b0, conv_ctrl_pkg::RES_HIGH_ADDR, 32'h0);
      check(q, {24'h0, e[9:2]}, "high");
      bus(1'b0, conv_ctrl_pkg::RES_LOW_ADDR, 32'h0);
      check(q, {30'h0, e[1:0]}, "low");
      check(irq, en, "irq");
      check(gap, div(p), "tick gap");
      if (!en) begin
        bus(1'b1, conv_ctrl_pkg::IRQ_EN_ADDR, 32'h2);
        @(posedge clk_i);
        check(irq, 1'b1, "unmasked irq");
      end
      bus(1'b1, conv_ctrl_pkg::IRQ_STAT_ADDR, 32'h10);
      @(posedge clk_i);
      check(irq, 1'b0, "cleared irq");
    end
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    give_verdict();
  end
endmodule : tb
